// File: rtl/pxb_pkg.sv
`default_nettype none

package pxb_pkg;

	// =========================================================
	// Register indices; byte address is four times the index
	localparam logic [7:0] PXB_IDX_P0DAT = 8'h80;
	localparam logic [7:0] PXB_IDX_P1DAT = 8'h90;
	localparam logic [7:0] PXB_IDX_P0DRV = 8'ha4;
	localparam logic [7:0] PXB_IDX_P1DRV = 8'ha5;
	localparam logic [7:0] PXB_IDX_P1KND = 8'hbd;
	localparam logic [7:0] PXB_IDX_SELA  = 8'he1;
	localparam logic [7:0] PXB_IDX_SELB  = 8'he2;
	localparam logic [7:0] PXB_IDX_SELC  = 8'he3;
	localparam logic [7:0] PXB_IDX_MCFG  = 8'hc0;

	// =========================================================
	// Reset values
	localparam logic [7:0] PXB_RST_DAT = 8'hff;
	localparam logic [7:0] PXB_RST_DRV = 8'h00;
	localparam logic [7:0] PXB_RST_KND = 8'hff;
	localparam logic [7:0] PXB_RST_SEL = 8'h00;
	localparam logic [7:0] PXB_RST_MCFG = 8'h00;

	// =========================================================
	// Field positions
	localparam int PXB_A_CMPA = 7;
	localparam int PXB_A_ECI  = 6;
	localparam int PXB_A_MODH = 5;
	localparam int PXB_A_MODL = 3;
	localparam int PXB_A_SERA = 2;
	localparam int PXB_A_SPI  = 1;
	localparam int PXB_A_SMB  = 0;
	localparam int PXB_B_CLKO = 7;
	localparam int PXB_B_T2EX = 6;
	localparam int PXB_B_T2   = 5;
	localparam int PXB_B_INTB = 4;
	localparam int PXB_B_T1   = 3;
	localparam int PXB_B_INTA = 2;
	localparam int PXB_B_T0   = 1;
	localparam int PXB_B_CMPB = 0;
	localparam int PXB_C_PUOFF = 7;
	localparam int PXB_C_XBAR  = 6;
	localparam int PXB_C_UNUSED = 5;
	localparam int PXB_C_T4EX  = 4;
	localparam int PXB_C_T4    = 3;
	localparam int PXB_C_SERB  = 2;
	localparam int PXB_C_MEMIF = 1;
	localparam int PXB_C_CONV  = 0;
	localparam int PXB_M_NONMUX = 4;
	localparam logic [2:0] PXB_MOD_MAX = 3'h5;

	// =========================================================
	// Peripheral signals in crossbar priority order
	localparam int PXB_NSIG   = 28;
	localparam int PXB_NPIN   = 16;
	localparam int PXB_S_TXA  = 0;
	localparam int PXB_S_RXA  = 1;
	localparam int PXB_S_SPI  = 2;
	localparam int PXB_S_SDA  = 6;
	localparam int PXB_S_SCL  = 7;
	localparam int PXB_S_TXB  = 8;
	localparam int PXB_S_RXB  = 9;
	localparam int PXB_S_CEX  = 10;
	localparam int PXB_S_ECI  = 15;
	localparam int PXB_S_CMPA = 16;
	localparam int PXB_S_CMPB = 17;
	localparam int PXB_S_T0   = 18;
	localparam int PXB_S_INTA = 19;
	localparam int PXB_S_T1   = 20;
	localparam int PXB_S_INTB = 21;
	localparam int PXB_S_T2   = 22;
	localparam int PXB_S_T2EX = 23;
	localparam int PXB_S_T4   = 24;
	localparam int PXB_S_T4EX = 25;
	localparam int PXB_S_CLKO = 26;
	localparam int PXB_S_CONV = 27;

	// Block state
	typedef struct packed {
		logic [7:0]  port0_data;
		logic [7:0]  port1_data;
		logic [7:0]  port0_output_drive;
		logic [7:0]  port1_output_drive;
		logic [7:0]  port1_input_kind;
		logic [7:0]  routing_select_a;
		logic [7:0]  routing_select_b;
		logic [7:0]  routing_select_c;
		logic [7:0]  memif_config;
		logic [31:0] prdata;
	} pxb_state_t;

	// Byte address of a register index
	function automatic logic [9:0] pxb_addr(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction

endpackage

`default_nettype wire

// File: rtl/pxb_route.sv
`default_nettype none

// =============================================================
// Priority assignment of enabled signals to free pins
module pxb_route import pxb_pkg::*; #(
	parameter int NSIG = PXB_NSIG,
	parameter int NPIN = PXB_NPIN
) (
	// Requests
	input  wire logic [NSIG-1:0]      sig_en,
	input  wire logic [NPIN-1:0]      pin_skip,
	// Result
	output logic      [NPIN-1:0]      pin_hit,
	output logic      [NPIN-1:0][4:0] pin_sel
);

	// k-th free pin takes k-th enabled signal
	always_comb begin
		int k;
		int r;
		k = 0;
		r = 0;
		pin_hit = '0;
		pin_sel = '0;
		for (int p = 0; p < NPIN; p++) begin
			if (!pin_skip[p]) begin // see RL23
				r = 0;
				for (int s = 0; s < NSIG; s++) begin
					if (sig_en[s]) begin
						if (r == k && !pin_hit[p]) begin
							pin_hit[p] = 1'b1;
							pin_sel[p] = 5'(s);
						end
						r++;
					end
				end
				k++;
			end
		end
	end

endmodule

`default_nettype wire

// File: rtl/pxb_top.sv
// Chosen here: the APB interface to the registers.
`default_nettype none

// Function
// RL1: Select A bit 7 puts comparator A output on a pin, else none.
// RL2: Select A bit 6 routes counter array external count input.
// RL3: Select A bits 5-3 route first N module signals; 110, 111 reserved.
// RL4: Serial A route puts transmit on pin 0.0, receive on 0.1.
// RL5: SPI route bit places its four signals on four pins.
// RL6: SMBus route bit places data and clock on two pins.
// RL7: Select B bit 7 routes inverted clock out, bit 0 comparator B.
// RL8: Select B bits 6-1 route timer and interrupt inputs from pins.
// RL9: Select C bit 7 set turns all weak pull-ups off.
// RL10: Crossbar enable clear disables routing, all pins inputs.
// RL11: Select C bit 5 reads zero, writes ignored.
// RL12: Select C bits 4,3 route timer four inputs; bit 2 serial B.
// RL13: Memory claim, multiplexed: pins 0.7, 0.6, 0.5 skipped.
// RL14: Memory claim, non-multiplexed: only pins 0.7 and 0.6 skipped.
// RL15: Select C bit 0 routes convert-start input from a pin.
// RL16: Data write sets latches; 1 is open unless push-pull.
// RL17: Data register reads return pin levels regardless of routing.
// RL18: Output drive bit 0 open-drain, 1 push-pull.
// RL19: SMBus pins and mode-0 receive pins are always open-drain.
// RL20: Port 1 analog bit: digital read zero, pull-up off.
// RL21: Port 1 digital bit: read pin, pull-up per global bit.
// RL22: Analog port 1 pins skipped; latch and drive bits still apply.
// RL23: Signals fill pins in fixed order from pin 0.0, skipping claimed.
// RL24: Interrupt A route bit routes interrupt A input.
module pxb_top import pxb_pkg::*; #(
	parameter int NSIG = PXB_NSIG,
	parameter int NPIN = PXB_NPIN
) (
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// APB slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [9:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Port pins 0.0 to 1.7
	input  wire logic [NPIN-1:0] pin_i,
	output logic      [NPIN-1:0] pin_o,
	output logic      [NPIN-1:0] pin_oe,
	output logic      [NPIN-1:0] pullup_en,
	// Peripheral side
	input  wire logic [NSIG-1:0] periph_out,
	input  wire logic [NSIG-1:0] periph_oe,
	output logic      [NSIG-1:0] periph_in,
	input  wire logic            serial_a_mode0,
	input  wire logic            serial_b_mode0,
	// Memory interface strobes for pins 0.5 to 0.7
	input  wire logic [7:5]      memif_out
);

	// =========================================================
	// State
	pxb_state_t st;
	pxb_state_t next_st;

	logic [NSIG-1:0]      sig_en;
	logic [NSIG-1:0]      forced_od;
	logic [NSIG-1:0]      sig_on_pin;
	logic [NPIN-1:0]      pin_skip;
	logic [NPIN-1:0]      pin_hit;
	logic [NPIN-1:0][4:0] pin_sel;
	logic [NPIN-1:0]      latch;
	logic [NPIN-1:0]      pushpull;
	logic [2:0]           mod_cnt;
	logic                 xbar_on;
	logic                 claim;
	logic                 nonmux;
	logic                 setup;
	logic                 access;
	logic                 known;
	logic [7:0]           rd_val;

	assign xbar_on  = st.routing_select_c[PXB_C_XBAR];
	assign claim    = st.routing_select_c[PXB_C_MEMIF];
	assign nonmux   = st.memif_config[PXB_M_NONMUX];
	assign latch    = {st.port1_data, st.port0_data};
	assign pushpull = {st.port1_output_drive, st.port0_output_drive};

	// =========================================================
	// Signal enables from the routing selects

	// Module count, reserved codes route nothing
	assign mod_cnt = (st.routing_select_a[PXB_A_MODH:PXB_A_MODL]
		> PXB_MOD_MAX) ? 3'h0 // see RL3
		: st.routing_select_a[PXB_A_MODH:PXB_A_MODL];

	// Enable vector, all off while crossbar is disabled
	always_comb begin
		sig_en = '0;
		sig_en[PXB_S_TXA] = st.routing_select_a[PXB_A_SERA]; // see RL4
		sig_en[PXB_S_RXA] = st.routing_select_a[PXB_A_SERA]; // see RL4
		for (int i = 0; i < 4; i++) begin
			sig_en[PXB_S_SPI+i] = st.routing_select_a[PXB_A_SPI]; // see RL5
		end
		sig_en[PXB_S_SDA] = st.routing_select_a[PXB_A_SMB]; // see RL6
		sig_en[PXB_S_SCL] = st.routing_select_a[PXB_A_SMB]; // see RL6
		sig_en[PXB_S_TXB] = st.routing_select_c[PXB_C_SERB]; // see RL12
		sig_en[PXB_S_RXB] = st.routing_select_c[PXB_C_SERB]; // see RL12
		for (int i = 0; i < 5; i++) begin
			sig_en[PXB_S_CEX+i] = (32'(mod_cnt) > i); // see RL3
		end
		sig_en[PXB_S_ECI]  = st.routing_select_a[PXB_A_ECI]; // see RL2
		sig_en[PXB_S_CMPA] = st.routing_select_a[PXB_A_CMPA]; // see RL1
		sig_en[PXB_S_CMPB] = st.routing_select_b[PXB_B_CMPB]; // see RL7
		sig_en[PXB_S_T0]   = st.routing_select_b[PXB_B_T0]; // see RL8
		sig_en[PXB_S_INTA] = st.routing_select_b[PXB_B_INTA]; // see RL24
		sig_en[PXB_S_T1]   = st.routing_select_b[PXB_B_T1]; // see RL8
		sig_en[PXB_S_INTB] = st.routing_select_b[PXB_B_INTB]; // see RL8
		sig_en[PXB_S_T2]   = st.routing_select_b[PXB_B_T2]; // see RL8
		sig_en[PXB_S_T2EX] = st.routing_select_b[PXB_B_T2EX]; // see RL8
		sig_en[PXB_S_T4]   = st.routing_select_c[PXB_C_T4]; // see RL12
		sig_en[PXB_S_T4EX] = st.routing_select_c[PXB_C_T4EX]; // see RL12
		sig_en[PXB_S_CLKO] = st.routing_select_b[PXB_B_CLKO]; // see RL7
		sig_en[PXB_S_CONV] = st.routing_select_c[PXB_C_CONV]; // see RL15
		if (!xbar_on) begin
			sig_en = '0; // see RL10
		end
	end

	// Signals driven open-drain: SMBus always, serial receive in mode 0
	always_comb begin
		forced_od = '0;
		forced_od[PXB_S_SDA] = 1'b1; // see RL19
		forced_od[PXB_S_SCL] = 1'b1; // see RL19
		forced_od[PXB_S_RXA] = serial_a_mode0; // see RL19
		forced_od[PXB_S_RXB] = serial_b_mode0; // see RL19
	end

	// =========================================================
	// Pin skipping and assignment

	// Memory claim on port 0, analog pins on port 1
	assign pin_skip[7:6] = {2{claim}}; // see RL14
	assign pin_skip[5]   = claim & ~nonmux; // see RL13
	assign pin_skip[4:0] = 5'h00;
	assign pin_skip[15:8] = ~st.port1_input_kind; // see RL22

	pxb_route #(
		.NSIG (NSIG),
		.NPIN (NPIN)
	) u_route (
		.sig_en   (sig_en),
		.pin_skip (pin_skip),
		.pin_hit  (pin_hit),
		.pin_sel  (pin_sel)
	);

	// =========================================================
	// Pin drivers and peripheral inputs

	// Drive value, open-drain choice and return path per pin
	always_comb begin
		logic val;
		logic drv;
		logic od;
		val = 1'b0;
		drv = 1'b0;
		od  = 1'b0;
		pin_o = '0;
		pin_oe = '0;
		periph_in = '1;
		for (int p = 0; p < NPIN; p++) begin
			val = latch[p]; // see RL16
			drv = 1'b1;
			od  = ~pushpull[p]; // see RL18
			if (pin_hit[p]) begin
				val = periph_out[pin_sel[p]];
				drv = periph_oe[pin_sel[p]];
				od  = od | forced_od[pin_sel[p]]; // see RL19
				periph_in[pin_sel[p]] = pin_i[p];
			end else if (p >= 5 && p <= 7 && pin_skip[p]) begin
				val = latch[p] & memif_out[p]; // see RL13
			end
			pin_o[p]  = val;
			pin_oe[p] = xbar_on & drv & (~val | ~od); // see RL10
		end
	end

	// Weak pull-ups, off globally or on analog pins
	assign pullup_en = {st.port1_input_kind, 8'hff} // see RL20
		& {NPIN{~st.routing_select_c[PXB_C_PUOFF]}}; // see RL9, RL21

	// Helper: which signals reach any pin
	always_comb begin
		sig_on_pin = '0;
		for (int p = 0; p < NPIN; p++) begin
			if (pin_hit[p]) begin
				sig_on_pin[pin_sel[p]] = 1'b1;
			end
		end
	end

	// =========================================================
	// APB slave

	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign pready = 1'b1;
	assign pslverr = access & ~known;
	assign prdata = st.prdata;

	// Address decode and read mux
	always_comb begin
		known = 1'b1;
		rd_val = 8'h00;
		case (paddr)
			pxb_addr(PXB_IDX_P0DAT): begin
				rd_val = pin_i[7:0]; // see RL17
			end
			pxb_addr(PXB_IDX_P1DAT): begin
				rd_val = pin_i[15:8] & st.port1_input_kind; // see RL20
			end
			pxb_addr(PXB_IDX_P0DRV): rd_val = st.port0_output_drive;
			pxb_addr(PXB_IDX_P1DRV): rd_val = st.port1_output_drive;
			pxb_addr(PXB_IDX_P1KND): rd_val = st.port1_input_kind;
			pxb_addr(PXB_IDX_SELA): rd_val = st.routing_select_a;
			pxb_addr(PXB_IDX_SELB): rd_val = st.routing_select_b;
			pxb_addr(PXB_IDX_SELC): rd_val = st.routing_select_c;
			pxb_addr(PXB_IDX_MCFG): rd_val = st.memif_config;
			default: known = 1'b0;
		endcase
	end

	// Next state: writes in access phase, read data in setup
	always_comb begin
		next_st = st;
		if (setup && !pwrite) begin
			next_st.prdata = {24'h000000, rd_val};
		end
		if (access && pwrite && known) begin
			case (paddr)
				pxb_addr(PXB_IDX_P0DAT): begin
					next_st.port0_data = pwdata[7:0]; // see RL16
				end
				pxb_addr(PXB_IDX_P1DAT): begin
					next_st.port1_data = pwdata[7:0]; // see RL16
				end
				pxb_addr(PXB_IDX_P0DRV): begin
					next_st.port0_output_drive = pwdata[7:0];
				end
				pxb_addr(PXB_IDX_P1DRV): begin
					next_st.port1_output_drive = pwdata[7:0];
				end
				pxb_addr(PXB_IDX_P1KND): begin
					next_st.port1_input_kind = pwdata[7:0];
				end
				pxb_addr(PXB_IDX_SELA): begin
					next_st.routing_select_a = pwdata[7:0];
				end
				pxb_addr(PXB_IDX_SELB): begin
					next_st.routing_select_b = pwdata[7:0];
				end
				pxb_addr(PXB_IDX_SELC): begin
					next_st.routing_select_c = pwdata[7:0];
					next_st.routing_select_c[PXB_C_UNUSED] = 1'b0; // see RL11
				end
				pxb_addr(PXB_IDX_MCFG): begin
					next_st.memif_config = pwdata[7:0];
				end
				default: next_st.memif_config = st.memif_config;
			endcase
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.port0_data         <= PXB_RST_DAT;
			st.port1_data         <= PXB_RST_DAT;
			st.port0_output_drive <= PXB_RST_DRV;
			st.port1_output_drive <= PXB_RST_DRV;
			st.port1_input_kind   <= PXB_RST_KND;
			st.routing_select_a   <= PXB_RST_SEL;
			st.routing_select_b   <= PXB_RST_SEL;
			st.routing_select_c   <= PXB_RST_SEL;
			st.memif_config       <= PXB_RST_MCFG;
			st.prdata             <= 32'h00000000;
		end else begin
			st <= next_st;
		end
	end

	// =========================================================
	// Assertions

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Write and read transfers to one register
	sequence s_wr(logic [7:0] idx);
		psel && penable && pwrite && paddr == pxb_addr(idx);
	endsequence

	sequence s_rd(logic [7:0] idx);
		psel && !penable && !pwrite && paddr == pxb_addr(idx)
		##1 psel && penable;
	endsequence

	a_latch_write: assert property ( // see RL16
		s_wr(PXB_IDX_P0DAT) |=> st.port0_data == $past(pwdata[7:0])
	) else $error("port 0 latch not written");

	a_pin_read: assert property ( // see RL17
		s_rd(PXB_IDX_P0DAT) |-> prdata[7:0] == $past(pin_i[7:0])
	) else $error("port 0 read is not the pin level");

	a_analog_read: assert property ( // see RL20
		s_rd(PXB_IDX_P1DAT)
		|-> (prdata[7:0] & ~st.port1_input_kind) == 8'h00
	) else $error("analog pin read not zero");

	a_unused_bit: assert property ( // see RL11
		s_rd(PXB_IDX_SELC) |-> prdata[PXB_C_UNUSED] == 1'b0
	) else $error("unused select bit reads one");

	a_xbar_off: assert property ( // see RL10
		!xbar_on |-> pin_oe == '0 && pin_hit == '0
	) else $error("pin driven while crossbar off");

	a_open_drain: assert property ( // see RL18
		(pin_oe & pin_o & ~pushpull & ~pin_hit) == '0
	) else $error("open-drain pin driven high");

	a_smbus_od: assert property ( // see RL19
		pin_hit[0] ##0 pin_sel[0] == 5'(PXB_S_SDA) |-> !(pin_oe[0] && pin_o[0])
	) else $error("SMBus pin driven high");

	a_serial_pins: assert property ( // see RL4
		xbar_on && st.routing_select_a[PXB_A_SERA]
		|-> pin_hit[1:0] == 2'b11 && pin_sel[0] == 5'(PXB_S_TXA)
			&& pin_sel[1] == 5'(PXB_S_RXA)
	) else $error("serial A not on pins 0.0 and 0.1");

	a_cmp_off: assert property ( // see RL1
		!st.routing_select_a[PXB_A_CMPA] |-> !sig_on_pin[PXB_S_CMPA]
	) else $error("comparator A on a pin while off");

	a_memif_skip: assert property ( // see RL13
		claim && !nonmux |-> pin_hit[7:5] == 3'b000
	) else $error("claimed memory pin assigned");

	a_analog_skip: assert property ( // see RL22
		(pin_hit[15:8] & ~st.port1_input_kind) == 8'h00
	) else $error("analog pin assigned");

	a_pullup_off: assert property ( // see RL9
		st.routing_select_c[PXB_C_PUOFF] |-> pullup_en == '0
	) else $error("pull-up on while disabled");

endmodule

`default_nettype wire

// File: verif/pxb_pins.sv
`default_nettype none

// =============================================================
// Outside circuitry on the sixteen port pins
module pxb_pins (
	// Clock
	input  wire logic        pclk,
	// Device side of each pin
	input  wire logic [15:0] pin_o,
	input  wire logic [15:0] pin_oe,
	input  wire logic [15:0] pullup_en,
	// Outside drivers
	input  wire logic [15:0] ext_drv,
	input  wire logic [15:0] ext_val,
	// Resolved wire level
	output logic      [15:0] pin_i
);
	timeunit 1ns;
	timeprecision 100ps;

	logic tog = 1'b0;

	// Free-running pattern for a floating pin
	always @(posedge pclk) begin
		tog <= !tog;
	end

	// Device drive wins, then outside drive, then pull-up, else floats
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pin_oe[i]) begin
				pin_i[i] = pin_o[i];
			end else if (ext_drv[i]) begin
				pin_i[i] = ext_val[i];
			end else if (pullup_en[i]) begin
				pin_i[i] = 1'b1;
			end else begin
				pin_i[i] = tog ^ i[0];
			end
		end
	end
endmodule

`default_nettype wire

// File: verif/pxb_top_bench.sv
`default_nettype none

// =============================================================
// Crossbar bench against a behavioural mirror
module pxb_top_bench import pxb_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pin_i, pin_o, pin_oe, pullup_en, ext_drv, ext_val;
	logic [27:0] periph_out, periph_oe, periph_in;
	logic        sa_m0, sb_m0, er;
	logic [7:5]  memif_out;
	logic [7:0]  r[9];
	logic [15:0] e_o, e_oe, e_pu;
	logic [27:0] e_in;
	int          sig_at[16];
	int          err_count, num_checks;
	logic [7:0]  idx_t[9] = '{PXB_IDX_P0DAT, PXB_IDX_P1DAT, PXB_IDX_P0DRV,
		PXB_IDX_P1DRV, PXB_IDX_P1KND, PXB_IDX_SELA, PXB_IDX_SELB,
		PXB_IDX_SELC, PXB_IDX_MCFG};
	logic [7:0]  rst_t[9] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00,
		8'h00, 8'h00, 8'h00};

	pxb_top u_pxb_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe(pin_oe), .pullup_en(pullup_en),
		.periph_out(periph_out), .periph_oe(periph_oe),
		.periph_in(periph_in), .serial_a_mode0(sa_m0),
		.serial_b_mode0(sb_m0), .memif_out(memif_out));

	pxb_pins u_pxb_pins (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe),
		.pullup_en(pullup_en), .ext_drv(ext_drv), .ext_val(ext_val),
		.pin_i(pin_i));

	// Clock at 40 MHz
	always #12.5 pclk = !pclk;

	// =========================================================
	// Reporting
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk_bus(input logic [31:0] got, exp, msk);
		num_checks++;
		if ((got & msk) !== (exp & msk)) begin
			err_count++;
			$display("unexpected %0t bus got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [31:0] got, exp, msk);
		num_checks++;
		if ((got & msk) !== (exp & msk)) begin
			err_count++;
			$display("unexpected %0t pin got %h exp %h", $time, got, exp);
		end
	endtask

	// =========================================================
	// APB master: setup, access until pready, then release
	task automatic apb(input logic [7:0] idx, input logic wr,
		input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= {idx, 2'b00};
		pwrite <= wr;
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			$display("unexpected %0t bus hang", $time);
			end_sim();
		end
	endtask

	// =========================================================
	// Mirror of routing, pin drive and pull-ups
	function automatic void model();
		logic [27:0] en;
		logic [15:0] skip, lat, drv;
		logic [7:0]  a, b, c;
		logic        od;
		int          k, p;
		a = r[5];
		b = r[6];
		c = r[7];
		lat = {r[1], r[0]};
		drv = {r[3], r[2]};
		en = '0;
		en[1:0] = {2{a[2]}};
		en[5:2] = {4{a[1]}};
		en[7:6] = {2{a[0]}};
		en[9:8] = {2{c[2]}};
		for (k = 0; k < 5; k++) begin
			en[10+k] = a[5:3] <= PXB_MOD_MAX && k < a[5:3];
		end
		en[27:15] = {c[0], b[7], c[4], c[3], b[6], b[5], b[4], b[3], b[2],
			b[1], b[0], a[7], a[6]};
		if (!c[6]) begin
			en = '0;
		end
		skip = {~r[4], 8'h00};
		if (c[1]) begin
			skip[7:5] = r[8][PXB_M_NONMUX] ? 3'b110 : 3'b111;
		end
		sig_at = '{default: -1};
		p = 0;
		for (k = 0; k < 28; k++) begin
			while (en[k] && p < 16 && skip[p]) p++;
			if (en[k] && p < 16) begin
				sig_at[p] = k;
				p++;
			end
		end
		e_in = '1;
		for (p = 0; p < 16; p++) begin
			k = sig_at[p];
			if (k >= 0) begin
				e_in[k] = pin_i[p];
				e_o[p] = periph_out[k];
				od = k == 6 || k == 7 || (k == 1 && sa_m0) || (k == 9 && sb_m0);
				e_oe[p] = periph_oe[k] & (!e_o[p] | (drv[p] & !od));
			end else begin
				e_o[p] = lat[p];
				if (p >= 5 && p < 8 && c[1] && skip[p]) begin
					e_o[p] = lat[p] & memif_out[p];
				end
				e_oe[p] = !e_o[p] | drv[p];
			end
			if (!c[6]) begin
				e_oe[p] = 1'b0;
			end
			e_pu[p] = !c[7] && !(p >= 8 && !r[4][p-8]);
		end
	endfunction

	// =========================================================
	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, sa_m0, sb_m0} = '0;
		paddr = '0;
		pwdata = '0;
		{ext_drv, ext_val, periph_out, periph_oe} = '0;
		memif_out = '0;
		void'($urandom(27));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset state of pins and registers
		for (int k = 0; k < 9; k++) begin
			r[k] = rst_t[k];
		end
		@(negedge pclk);
		model();
		chk_pin(pin_oe, 0, 32'hffff);
		chk_pin(pullup_en, e_pu, 32'hffff);
		chk_pin(periph_in, e_in, 32'hfffffff);
		for (int k = 0; k < 9; k++) begin
			apb(idx_t[k], 1'b0, 8'h00);
			chk_bus(rd, {24'h0, rst_t[k]}, 32'hffffffff);
			chk_bus({31'h0, er}, 32'h0, 32'h1);
		end
		// Unmapped place refuses
		apb(8'h00, 1'b0, 8'h00);
		chk_bus({31'h0, er}, 32'h1, 32'h1);
		chk_bus(rd, 32'h0, 32'hffffffff);
		ext_drv <= 16'hffff;
		for (int i = 0; i < 48; i++) begin
			for (int k = 0; k < 9; k++) begin
				r[k] = 8'($urandom);
			end
			r[5][5:3] = 3'(i);
			r[7][6] = (i % 6) != 0;
			apb(8'h00, 1'b1, 8'h5a);
			chk_bus({31'h0, er}, 32'h1, 32'h1);
			periph_out <= 28'($urandom);
			periph_oe <= 28'($urandom);
			ext_val <= 16'($urandom);
			{sa_m0, sb_m0} <= 2'($urandom);
			memif_out <= 3'($urandom);
			for (int k = 0; k < 9; k++) begin
				apb(idx_t[k], 1'b1, r[k]);
			end
			r[7][PXB_C_UNUSED] = 1'b0;
			repeat (4) @(posedge pclk);
			@(negedge pclk);
			model();
			chk_pin(pin_oe, e_oe, 32'hffff);
			chk_pin(pin_o, e_o, e_oe);
			chk_pin(pullup_en, e_pu, 32'hffff);
			chk_pin(periph_in, e_in, 32'hfffffff);
			for (int k = 2; k < 9; k++) begin
				apb(idx_t[k], 1'b0, 8'h00);
				chk_bus(rd, {24'h0, r[k]}, k == 8 ? 32'h10 : '1);
			end
			apb(idx_t[0], 1'b0, 8'h00);
			chk_bus(rd, {24'h0, pin_i[7:0]}, '1);
			apb(idx_t[1], 1'b0, 8'h00);
			chk_bus(rd, {24'h0, pin_i[15:8] & r[4]}, '1);
		end
		end_sim();
	end
endmodule

`default_nettype wire
